// >>> core/psb_map.svh
// Purpose: constants shared by both ends of the processor system bus
// Assumes: 10 MHz system clock
// Notes:   pin vectors are numbered with line 0 as the msb
`ifndef PSB_MAP_SVH
`define PSB_MAP_SVH

`define PSB_ADDR_W         16
`define PSB_DATA_W         16
`define PSB_PARITY_BIT     16
`define PSB_SYS_CLK_NS     100
`define PSB_TIMER_CLOCK_PERIOD_NS 10000
`define PSB_TIMER_CLOCK_HALF_CYC  ((`PSB_TIMER_CLOCK_PERIOD_NS / `PSB_SYS_CLK_NS) / 2)
`define PSB_TIMER_CLOCK_MIN_RATIO 9
`define PSB_NUM_COUNTERS   3
`define PSB_TIMER_A        0
`define PSB_TIMER_B        1
`define PSB_TRIGGER_GO     2
`define PSB_FAULT_W        3
`define PSB_FAULT_MEM      0
`define PSB_FAULT_IO       1
`define PSB_FAULT_PARITY   2
`define PSB_MEM_DEPTH      256
`define PSB_MEM_IDX_W      8

`endif

// >>> core/psb_pkg.sv
// Purpose: types shared by both ends of the processor system bus
// Assumes: psb_map.svh constants
// Notes:   none
`include "psb_map.svh"

package psb_pkg;
   typedef logic [0:`PSB_ADDR_W-1] psb_addr_t;
   typedef logic [0:`PSB_DATA_W] psb_word_t;
   typedef enum logic [2:0] {PSB_IDLE, PSB_ADDR, PSB_STRB, PSB_HOLD, PSB_END} psb_cyc_t;
   typedef enum logic [1:0] {PSB_ALT_IDLE, PSB_ALT_ADDR, PSB_ALT_STRB} psb_alt_t;
endpackage

// >>> core/psb_if.sv
// Purpose: system bus wires between the processor end and the bus end
// Assumes: each end drives value plus enable for every shared line
// Notes:   an undriven line settles to its idle level
`timescale 1ns/1ps
`default_nettype none

interface psb_if;
   import psb_pkg::*;
   logic      cpu_grant;
   logic      ref_clock_out;
   logic      timer_clock;
   logic      bus_fault;
   psb_addr_t cpu_addr_o, oth_addr_o, addr_bus_lines;
   logic      cpu_addr_oe, oth_addr_oe;
   psb_word_t cpu_data_o, oth_data_o, data_bus_lines;
   logic      cpu_data_oe, oth_data_oe;
   logic      cpu_as_o, cpu_as_oe, oth_as_o, oth_as_oe, address_strobe;
   logic      cpu_ds_o, cpu_ds_oe, oth_ds_o, oth_ds_oe, data_strobe_low;
   logic      cpu_mio_o, cpu_mio_oe, oth_mio_o, oth_mio_oe, mem_io_select;
   logic      cpu_rw_o, cpu_rw_oe, oth_rw_o, oth_rw_oe, read_write_dir;

   assign addr_bus_lines  = cpu_addr_oe ? cpu_addr_o : (oth_addr_oe ? oth_addr_o : '0);
   assign data_bus_lines  = cpu_data_oe ? cpu_data_o : (oth_data_oe ? oth_data_o : '0);
   assign address_strobe  = cpu_as_oe ? cpu_as_o : (oth_as_oe & oth_as_o);
   assign data_strobe_low = cpu_ds_oe ? cpu_ds_o : (~oth_ds_oe | oth_ds_o);
   assign mem_io_select   = cpu_mio_oe ? cpu_mio_o : (~oth_mio_oe | oth_mio_o);
   assign read_write_dir  = cpu_rw_oe ? cpu_rw_o : (~oth_rw_oe | oth_rw_o);

   modport cpu_mp (
      input  cpu_grant, timer_clock, bus_fault, addr_bus_lines, data_bus_lines,
      input  address_strobe, data_strobe_low, mem_io_select, read_write_dir,
      output ref_clock_out, cpu_addr_o, cpu_addr_oe, cpu_data_o, cpu_data_oe,
      output cpu_as_o, cpu_as_oe, cpu_ds_o, cpu_ds_oe, cpu_mio_o, cpu_mio_oe,
      output cpu_rw_o, cpu_rw_oe
   );
   modport bus_mp (
      input  ref_clock_out, addr_bus_lines, data_bus_lines, address_strobe,
      input  data_strobe_low, mem_io_select, read_write_dir,
      output cpu_grant, timer_clock, bus_fault, oth_addr_o, oth_addr_oe,
      output oth_data_o, oth_data_oe, oth_as_o, oth_as_oe, oth_ds_o, oth_ds_oe,
      output oth_mio_o, oth_mio_oe, oth_rw_o, oth_rw_oe
   );
endinterface

`default_nettype wire

// >>> core/psb_cpu_end.sv
// Purpose: processor end of the system bus, with timers and fault register
// Assumes: bus inputs synchronous to sys_clk; one bus cycle per request
// Notes:   address and control pins change direction only in the idle state
`timescale 1ns/1ps
`default_nettype none
`include "psb_map.svh"

module psb_cpu_end
   import psb_pkg::*;
(
   input  wire logic                    sys_clk,
   input  wire logic                    reset,
   input  wire logic                    clk_en,
   psb_if.cpu_mp                        bus,
   input  wire logic                    req_valid,
   input  wire psb_addr_t               req_addr,
   input  wire logic                    req_read,
   input  wire logic                    req_mem,
   input  wire logic [0:`PSB_DATA_W-1]  req_wdata,
   input  wire logic                    parity_en,
   input  wire logic [`PSB_FAULT_W-1:0] fault_clear,
   output logic                         busy,
   output logic                         rsp_done,
   output logic [0:`PSB_DATA_W-1]       rsp_rdata,
   output logic [`PSB_FAULT_W-1:0]      fault_reg,
   output logic [`PSB_DATA_W-1:0]       timer_a,
   output logic [`PSB_DATA_W-1:0]       timer_b,
   output logic [`PSB_DATA_W-1:0]       trigger_go,
   output logic                         timer_clock_too_fast
);

   ////////////////////////////////////////////////////////////////////////////
   // state

   psb_cyc_t                      state_q, state_d;
   logic                          owned_q, owned_d;
   psb_addr_t                     addr_q;
   psb_word_t                     wdata_q;
   logic                          rw_q, mio_q, as_q, ds_low_q, data_oe_q, ref_q;
   logic                          busy_q, done_q;
   logic [0:`PSB_DATA_W-1]        rdata_q;
   logic [`PSB_FAULT_W-1:0]       fault_q, fault_set;
   logic                          as_prev_q, timer_clock_q, timer_clock_prev_q, too_fast_q;
   logic [3:0]                    gap_q;
   logic [`PSB_DATA_W-1:0]        cnt_q [`PSB_NUM_COUNTERS];

   ////////////////////////////////////////////////////////////////////////////
   // decode

   wire logic accept     = (state_q == PSB_IDLE) & req_valid & bus.cpu_grant;
   wire logic as_fall    = as_prev_q & ~bus.address_strobe;
   wire logic strobe_d   = (state_d == PSB_STRB) | (state_d == PSB_HOLD);
   wire logic drive_d    = (state_d == PSB_ADDR) | strobe_d;
   wire logic rd_parity  = ^bus.data_bus_lines;
   wire logic rd_cap     = (state_q == PSB_HOLD) & rw_q;
   wire logic parity_bad = rd_cap & parity_en & ~rd_parity;
   wire logic timer_clock_tick  = timer_clock_q & ~timer_clock_prev_q;
   wire logic wpar       = ~(^req_wdata);
   // write direction must be known as the cycle is entered
   wire logic rw_next    = accept ? req_read : rw_q;

   // faults land in the bit chosen by the select line, whoever drives it
   assign fault_set[`PSB_FAULT_MEM]    = as_fall & bus.bus_fault & bus.mem_io_select;
   assign fault_set[`PSB_FAULT_IO]     = as_fall & bus.bus_fault & ~bus.mem_io_select;
   assign fault_set[`PSB_FAULT_PARITY] = parity_bad;

   always_comb
   begin
      state_d = state_q;
      owned_d = owned_q;
      case (state_q)
         PSB_IDLE:
         begin
            owned_d = bus.cpu_grant;
            if (accept)
               state_d = PSB_ADDR;
         end
         PSB_ADDR: state_d = PSB_STRB;
         PSB_STRB: state_d = PSB_HOLD;
         PSB_HOLD: state_d = PSB_END;
         PSB_END:  state_d = PSB_IDLE;
         default:  state_d = PSB_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus cycle sequencer

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         state_q <= PSB_IDLE;
         owned_q <= 1'b0;
      end
      else if (clk_en)
      begin
         state_q <= state_d;
         owned_q <= owned_d;
      end
   end

   // address, direction and select are held for the whole cycle
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         addr_q  <= '0;
         rw_q    <= 1'b1;
         mio_q   <= 1'b1;
         wdata_q <= '0;
      end
      else if (clk_en && accept)
      begin
         addr_q  <= req_addr;
         rw_q    <= req_read;
         mio_q   <= req_mem;
         wdata_q <= {req_wdata, wpar};
      end
   end

   // strobes: address strobe high in the address phase, then falls
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         as_q      <= 1'b0;
         ds_low_q  <= 1'b1;
         data_oe_q <= 1'b0;
         busy_q    <= 1'b0;
      end
      else if (clk_en)
      begin
         as_q      <= state_d == PSB_ADDR;
         ds_low_q  <= ~strobe_d;
         data_oe_q <= owned_d & drive_d & ~rw_next;
         busy_q    <= state_d != PSB_IDLE;
      end
   end

   // reference clock toggles every cycle; strobes change on its edges
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         ref_q <= 1'b0;
      else if (clk_en)
         ref_q <= ~ref_q;
   end

   ////////////////////////////////////////////////////////////////////////////
   // read capture and fault register

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         rdata_q   <= '0;
         done_q    <= 1'b0;
         fault_q   <= '0;
         as_prev_q <= 1'b0;
      end
      else if (clk_en)
      begin
         if (rd_cap)
            rdata_q <= bus.data_bus_lines[0:`PSB_DATA_W-1];
         done_q    <= state_q == PSB_HOLD;
         as_prev_q <= bus.address_strobe;
         // a new fault wins over a clear in the same cycle
         fault_q   <= (fault_q & ~fault_clear) | fault_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // timers on the timer clock

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         timer_clock_q      <= 1'b0;
         timer_clock_prev_q <= 1'b0;
         gap_q       <= 4'hf;
         too_fast_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         timer_clock_q      <= bus.timer_clock;
         timer_clock_prev_q <= timer_clock_q;
         if (timer_clock_tick)
            gap_q <= 4'h1;
         else if (gap_q != 4'hf)
            gap_q <= gap_q + 4'h1;
         // timer edges closer than the minimum ratio set the too-fast flag; the count still takes them
         if (timer_clock_tick && gap_q < 4'(`PSB_TIMER_CLOCK_MIN_RATIO))
            too_fast_q <= 1'b1;
      end
   end

   for (genvar i = 0; i < `PSB_NUM_COUNTERS; i++)
   begin : g_cnt
      always_ff @(posedge sys_clk)
      begin
         if (reset)
            cnt_q[i] <= '0;
         else if (clk_en && timer_clock_tick)
            cnt_q[i] <= cnt_q[i] + 16'h0001;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pins: enables follow ownership, held through the cycle

   logic oe_q;
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         oe_q <= 1'b0;
      else if (clk_en)
         oe_q <= owned_d;
   end

   assign bus.ref_clock_out = ref_q;
   assign bus.cpu_addr_o    = addr_q;
   assign bus.cpu_addr_oe   = oe_q;
   assign bus.cpu_data_o    = wdata_q;
   assign bus.cpu_data_oe   = data_oe_q;
   assign bus.cpu_as_o      = as_q;
   assign bus.cpu_as_oe     = oe_q;
   assign bus.cpu_ds_o      = ds_low_q;
   assign bus.cpu_ds_oe     = oe_q;
   assign bus.cpu_mio_o     = mio_q;
   assign bus.cpu_mio_oe    = oe_q;
   assign bus.cpu_rw_o      = rw_q;
   assign bus.cpu_rw_oe     = oe_q;

   assign busy          = busy_q;
   assign rsp_done      = done_q;
   assign rsp_rdata     = rdata_q;
   assign fault_reg     = fault_q;
   assign timer_a       = cnt_q[`PSB_TIMER_A];
   assign timer_b       = cnt_q[`PSB_TIMER_B];
   assign trigger_go    = cnt_q[`PSB_TRIGGER_GO];
   assign timer_clock_too_fast = too_fast_q;

endmodule

`default_nettype wire

// >>> core/psb_bus_end.sv
// Purpose: far end of the system bus: memory, io word, arbiter, alternate master
// Assumes: processor end follows the address, strobe, hold, end sequence
// Notes:   only low 256 memory words exist; other memory addresses fault
`timescale 1ns/1ps
`default_nettype none
`include "psb_map.svh"

module psb_bus_end
   import psb_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       reset,
   input  wire logic       clk_en,
   psb_if.bus_mp           bus,
   input  wire logic       grant_to_cpu,
   input  wire logic       parity_en,
   input  wire logic       alt_req,
   input  wire psb_addr_t  alt_addr,
   input  wire logic       alt_mem,
   output logic            alt_busy,
   output logic            wr_parity_err,
   output logic [0:15]     io_word
);

   psb_alt_t                  alt_q, alt_d;
   logic                      grant_q, timer_clock_q, fault_q, data_oe_q, wperr_q;
   logic [6:0]                tdiv_q;
   psb_word_t                 rdata_q;
   psb_addr_t                 alt_addr_q;
   logic                      alt_mio_q;
   logic [0:15]               io_q;
   logic [0:15]               mem_q [`PSB_MEM_DEPTH];

   ////////////////////////////////////////////////////////////////////////////
   // decode

   wire logic [`PSB_MEM_IDX_W-1:0] idx = bus.addr_bus_lines[8:15];
   wire logic out_of_range = bus.addr_bus_lines[0:7] != 8'h00;
   wire logic rd_strobe    = ~bus.data_strobe_low & bus.read_write_dir;
   wire logic wr_strobe    = ~bus.data_strobe_low & ~bus.read_write_dir;
   wire logic [0:15] rword = bus.mem_io_select ? mem_q[idx] : io_q;
   wire logic alt_start    = (alt_q == PSB_ALT_IDLE) & alt_req & ~grant_q;
   wire logic tdiv_wrap    = tdiv_q == 7'(`PSB_TIMER_CLOCK_HALF_CYC - 1);

   always_comb
   begin
      alt_d = alt_q;
      case (alt_q)
         PSB_ALT_IDLE: if (alt_start) alt_d = PSB_ALT_ADDR;
         PSB_ALT_ADDR: alt_d = PSB_ALT_STRB;
         PSB_ALT_STRB: alt_d = PSB_ALT_IDLE;
         default:      alt_d = PSB_ALT_IDLE;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // arbiter, timer clock and alternate master

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         grant_q <= 1'b0;
         alt_q   <= PSB_ALT_IDLE;
         tdiv_q  <= '0;
         timer_clock_q  <= 1'b0;
      end
      else if (clk_en)
      begin
         // grant moves only while no alternate cycle is on the bus
         if (alt_d == PSB_ALT_IDLE)
            grant_q <= grant_to_cpu;
         alt_q  <= alt_d;
         tdiv_q <= tdiv_wrap ? 7'h00 : tdiv_q + 7'h01;
         if (tdiv_wrap)
            timer_clock_q <= ~timer_clock_q;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         alt_addr_q <= '0;
         alt_mio_q  <= 1'b1;
      end
      else if (clk_en && alt_start)
      begin
         alt_addr_q <= alt_addr;
         alt_mio_q  <= alt_mem;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // slave: fault sampled at address strobe, read data driven one cycle behind data strobe low

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         fault_q   <= 1'b0;
         data_oe_q <= 1'b0;
         rdata_q   <= '0;
         wperr_q   <= 1'b0;
         io_q      <= '0;
      end
      else if (clk_en)
      begin
         if (bus.address_strobe)
            fault_q <= bus.mem_io_select & out_of_range;
         data_oe_q <= rd_strobe;
         rdata_q   <= {rword, ~(^rword)};
         wperr_q   <= wr_strobe & parity_en & ~(^bus.data_bus_lines);
         if (wr_strobe && !bus.mem_io_select)
            io_q <= bus.data_bus_lines[0:15];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (clk_en && wr_strobe && bus.mem_io_select && !out_of_range)
         mem_q[idx] <= bus.data_bus_lines[0:15];
   end

   ////////////////////////////////////////////////////////////////////////////
   // pins

   assign bus.cpu_grant   = grant_q;
   assign bus.timer_clock = timer_clock_q;
   assign bus.bus_fault   = fault_q;
   assign bus.oth_addr_o  = alt_addr_q;
   assign bus.oth_addr_oe = alt_q != PSB_ALT_IDLE;
   assign bus.oth_data_o  = rdata_q;
   assign bus.oth_data_oe = data_oe_q;
   assign bus.oth_as_o    = alt_q == PSB_ALT_ADDR;
   assign bus.oth_as_oe   = alt_q != PSB_ALT_IDLE;
   assign bus.oth_ds_o    = 1'b1;
   assign bus.oth_ds_oe   = 1'b0;
   assign bus.oth_mio_o   = alt_mio_q;
   assign bus.oth_mio_oe  = alt_q != PSB_ALT_IDLE;
   assign bus.oth_rw_o    = 1'b1;
   assign bus.oth_rw_oe   = 1'b0;

   assign alt_busy      = alt_q != PSB_ALT_IDLE;
   assign wr_parity_err = wperr_q;
   assign io_word       = io_q;

endmodule

`default_nettype wire

// >>> verif/psb_checker.sv
// Purpose: concurrent checks on the shared wires of the first bus
// Assumes: one clock domain, synchronous active-high reset
// Notes:   sees the wires only, so request fields are checked by the bench
`timescale 1ns/1ps
`default_nettype none

module psb_checker
   import psb_pkg::*;
(
   input wire logic      sys_clk,
   input wire logic      reset,
   input wire logic      parity_en,
   input wire logic      cpu_grant,
   input wire logic      ref_clock_out,
   input wire logic      address_strobe,
   input wire logic      data_strobe_low,
   input wire logic      mem_io_select,
   input wire logic      read_write_dir,
   input wire psb_addr_t addr_bus_lines,
   input wire psb_word_t data_bus_lines,
   input wire logic      cpu_as_oe,
   input wire logic      cpu_addr_oe,
   input wire logic      cpu_data_oe,
   input wire logic      cpu_ds_oe,
   input wire logic      cpu_rw_oe,
   input wire logic      cpu_mio_oe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   ////////////////////////////////////////////////////////////////////////////////
   // a strobe rise counts as the processor end's own only while its own enable is set
   sequence own_strobe_s;
      $rose(address_strobe) && cpu_as_oe;
   endsequence

   sequence data_phase_s;
      (!address_strobe && !data_strobe_low) ##1 !data_strobe_low ##1 data_strobe_low;
   endsequence

   ////////////////////////////////////////////////////////////////////////////////
   ref_toggle_a: assert property (!$past(reset) |-> $changed(ref_clock_out))
      else $error("reference clock stalled");
   addr_valid_a: assert property (own_strobe_s |-> cpu_addr_oe ##1 $stable(addr_bus_lines))
      else $error("address not held after strobe rise");
   ds_order_a: assert property (own_strobe_s |=> data_phase_s)
      else $error("data strobe out of step");
   ctrl_hold_a: assert property (own_strobe_s |-> cpu_rw_oe && cpu_mio_oe
      ##1 ($stable(read_write_dir) && $stable(mem_io_select)) [*2])
      else $error("direction or select moved in a cycle");
   as_pulse_a: assert property ($rose(address_strobe) |=> $fell(address_strobe))
      else $error("address strobe not one cycle");
   bus_release_a: assert property (!cpu_grant && !$past(cpu_grant) |-> !cpu_addr_oe && !cpu_data_oe)
      else $error("buses driven without grant");
   strobe_release_a: assert property (!cpu_grant && !$past(cpu_grant)
      |-> !(cpu_ds_oe || cpu_rw_oe || cpu_mio_oe || cpu_as_oe))
      else $error("controls driven without grant");
   turn_boundary_a: assert property ($changed(cpu_addr_oe) |-> !address_strobe && data_strobe_low)
      else $error("turnaround inside a cycle");
   write_parity_a: assert property (parity_en && cpu_data_oe && !data_strobe_low |-> ^data_bus_lines)
      else $error("write parity not odd");
endmodule

`default_nettype wire

// >>> verif/processor_system_bus_interface_tb.sv
// Purpose: drives both bus ends and compares user sides and wires
// Assumes: inputs change 10 ns after the rising edge
// Notes:   a second processor end sees a too-fast timer clock
`timescale 1ns/1ps
`default_nettype none

module processor_system_bus_interface_tb;
   import psb_pkg::*;
   logic        sys_clk = 1'b0, reset = 1'b1, grant_to_cpu = 1'b0, parity_en = 1'b0;
   logic        req_valid = 1'b0, req_read = 1'b0, req_mem = 1'b0, alt_req = 1'b0;
   logic        alt_mem = 1'b0, busy, rsp_done, alt_busy, wr_parity_err, too_fast, fast_flag;
   psb_addr_t   req_addr = '0, alt_addr = '0, a;
   logic [0:15] req_wdata = '0, rsp_rdata, io_word, io_q;
   logic [0:15] mem_q [psb_addr_t];
   logic [2:0]  fault_clear = '0, fault_reg, fault_exp = '0;
   logic [15:0] timer_a, timer_b, trigger_go, ta, tb, tg;
   logic [31:0] r;
   integer      seed = 32'h32aa0ba7;
   int          miscompares = 0, samples_checked = 0, ops = 0, done_cnt = 0, perr_cnt = 0;

   always #50 sys_clk = ~sys_clk;

   psb_if bus_if();
   psb_if fast_if();
   psb_cpu_end psb_cpu_end_i (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .bus(bus_if.cpu_mp),
      .req_valid(req_valid), .req_addr(req_addr), .req_read(req_read), .req_mem(req_mem),
      .req_wdata(req_wdata), .parity_en(parity_en), .fault_clear(fault_clear), .busy(busy),
      .rsp_done(rsp_done), .rsp_rdata(rsp_rdata), .fault_reg(fault_reg), .timer_a(timer_a),
      .timer_b(timer_b), .trigger_go(trigger_go), .timer_clock_too_fast(too_fast));
   psb_bus_end psb_bus_end_i (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1), .bus(bus_if.bus_mp),
      .grant_to_cpu(grant_to_cpu), .parity_en(parity_en), .alt_req(alt_req), .alt_addr(alt_addr),
      .alt_mem(alt_mem), .alt_busy(alt_busy), .wr_parity_err(wr_parity_err), .io_word(io_word));
   // never granted, so it only shows the timer ratio flag
   psb_cpu_end psb_cpu_end_fast_i (.sys_clk(sys_clk), .reset(reset), .clk_en(1'b1),
      .bus(fast_if.cpu_mp), .req_valid(req_valid), .req_addr(req_addr), .req_read(req_read),
      .req_mem(req_mem), .req_wdata(req_wdata), .parity_en(parity_en), .fault_clear(fault_clear),
      .busy(), .rsp_done(), .rsp_rdata(), .fault_reg(), .timer_a(), .timer_b(), .trigger_go(),
      .timer_clock_too_fast(fast_flag));
   psb_checker psb_checker_i (.sys_clk(sys_clk), .reset(reset), .parity_en(parity_en),
      .cpu_grant(bus_if.cpu_grant), .ref_clock_out(bus_if.ref_clock_out),
      .address_strobe(bus_if.address_strobe), .data_strobe_low(bus_if.data_strobe_low),
      .mem_io_select(bus_if.mem_io_select), .read_write_dir(bus_if.read_write_dir),
      .addr_bus_lines(bus_if.addr_bus_lines), .data_bus_lines(bus_if.data_bus_lines),
      .cpu_as_oe(bus_if.cpu_as_oe), .cpu_addr_oe(bus_if.cpu_addr_oe),
      .cpu_data_oe(bus_if.cpu_data_oe), .cpu_ds_oe(bus_if.cpu_ds_oe),
      .cpu_rw_oe(bus_if.cpu_rw_oe), .cpu_mio_oe(bus_if.cpu_mio_oe));

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      fast_if.cpu_grant = 1'b0;
      fast_if.bus_fault = 1'b0;
      fast_if.timer_clock = 1'b0;
      fast_if.oth_addr_oe = 1'b0;
      fast_if.oth_data_oe = 1'b0;
      fast_if.oth_as_oe = 1'b0;
      fast_if.oth_ds_oe = 1'b0;
      fast_if.oth_mio_oe = 1'b0;
      fast_if.oth_rw_oe = 1'b0;
   end
   // edges two cycles apart, far under the ratio of nine
   always @(posedge sys_clk) fast_if.timer_clock <= ~fast_if.timer_clock;

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #10;
   endtask

   // only the low 256 memory words exist; io space never faults
   function automatic logic [2:0] access_fault(input logic mem, input psb_addr_t fa);
      return {2'b00, mem && (fa[0:7] != 8'h00)};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // wire-level view of every processor cycle, taken mid-cycle where lines are settled
   always @(negedge sys_clk)
   begin
      if (!reset && bus_if.cpu_as_oe && bus_if.address_strobe)
      begin
         check(bus_if.addr_bus_lines, req_addr);
         check(bus_if.mem_io_select, req_mem);
         check(bus_if.read_write_dir, req_read);
      end
      if (!reset && bus_if.cpu_ds_oe && !bus_if.data_strobe_low)
      begin
         check(bus_if.cpu_data_oe, !req_read);
         if (!req_read)
            check(bus_if.data_bus_lines[0:15], req_wdata);
         if (!req_read && parity_en)
            check(bus_if.data_bus_lines[16], ~^req_wdata);
      end
   end

   always @(posedge sys_clk)
   begin
      done_cnt += (rsp_done === 1'b1);
      perr_cnt += (wr_parity_err === 1'b1);
   end

   task automatic cpu_op(input logic rd, input logic mem, input psb_addr_t oa, input logic [0:15] d);
      int n;
      req_read = rd;
      req_mem = mem;
      req_addr = oa;
      req_wdata = d;
      req_valid = 1'b1;
      ops++;
      tick(1);
      req_valid = 1'b0;
      check(busy, 1'b1);
      n = 0;
      while (rsp_done !== 1'b1 && n < 10)
      begin
         tick(1);
         n++;
      end
      check(n, 3);
      fault_exp |= access_fault(mem, oa);
      if (rd && mem && mem_q.exists(oa))
         check(rsp_rdata, mem_q[oa]);
      if (rd && !mem)
         check(rsp_rdata, io_q);
      if (!rd && mem && fault_exp == 3'b000)
         mem_q[oa] = d;
      if (!rd && !mem)
         io_q = d;
      tick(1);
      check(fault_reg, fault_exp);
      check(busy, 1'b0);
      if (!rd && !mem)
         check(io_word, d);
      if (fault_exp != 3'b000)
      begin
         fault_clear = fault_exp;
         tick(1);
         fault_clear = '0;
         fault_exp = '0;
         check(fault_reg, 3'b000);
      end
   endtask

   task automatic alt_op(input logic mem, input psb_addr_t oa);
      alt_mem = mem;
      alt_addr = oa;
      alt_req = 1'b1;
      tick(1);
      alt_req = 1'b0;
      check(alt_busy, 1'b1);
      tick(5);
      fault_exp |= access_fault(mem, oa);
      check(fault_reg, fault_exp);
      check(alt_busy, 1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      tick(8);
      reset = 1'b0;
      grant_to_cpu = 1'b1;
      tick(3);
      ta = timer_a;
      tb = timer_b;
      tg = trigger_go;
      // a 1000-cycle window always holds exactly ten timer clock rises
      tick(1000);
      check(timer_a - ta, 16'h000a);
      check(timer_b - tb, 16'h000a);
      check(trigger_go - tg, 16'h000a);
      check({too_fast, fast_flag}, 2'b01);
      parity_en = 1'b1;
      cpu_op(1'b0, 1'b0, 16'hffff, 16'ha5a5);
      cpu_op(1'b1, 1'b0, 16'h0003, '0);
      cpu_op(1'b0, 1'b1, 16'h0000, 16'h8001);
      cpu_op(1'b1, 1'b1, 16'h0000, '0);
      cpu_op(1'b0, 1'b1, 16'h00ff, 16'h7ffe);
      cpu_op(1'b1, 1'b1, 16'h00ff, '0);
      cpu_op(1'b0, 1'b1, 16'h0100, 16'h1234);
      // foreign cycles with a request left pending: it must be refused
      grant_to_cpu = 1'b0;
      // the grant drops one edge late, so the request waits for it
      tick(2);
      req_valid = 1'b1;
      tick(3);
      alt_op(1'b1, 16'h0040);
      alt_op(1'b1, 16'h2000);
      alt_op(1'b0, 16'h2000);
      check(done_cnt, ops);
      req_valid = 1'b0;
      fault_clear = 3'b111;
      tick(1);
      fault_clear = '0;
      fault_exp = '0;
      grant_to_cpu = 1'b1;
      tick(3);
      repeat (150)
      begin
         r = $random(seed);
         parity_en = r[31];
         a = r[30] ? {12'h000, r[3:0]} : r[23:8];
         cpu_op(r[29], r[28] | r[27], a, r[15:0] ^ r[31:16]);
      end
      check(done_cnt, ops);
      check(perr_cnt, 0);
      final_report();
   end

   // the sequence needs about 1900 cycles; allow over five times that
   initial
   begin
      repeat (10000) @(posedge sys_clk);
      miscompares++;
      final_report();
   end
endmodule

`default_nettype wire
